// *** rtl/sfc_params.svh ***
// Overview of operation
// - Read 03h; fast read 0Bh adds dummy byte
// - Dual output: odd bits line one, even zero
// - Quad output: nibble per clock, high first
// - Quad I/O four per clock, four dummies
// - ABh: three dummies, device code repeats
// - Security address 00h, 10h/20h/30h, byte offset
// - Complete 06h frame sets write enable latch
// - Program, erase, non-volatile status write need latch set
// - 50h arms next status write, latch untouched
// - 04h clears latch and volatile arming
// - Latch cleared at reset and op completion
// - 05h/35h stream status MSB first, repeating
// - Status reads answered even while busy
// - Only status bits 7..2 and 14..8 writable
// - Lock bits one-time; volatile keeps second protect
// - Status write only after 8 or 16 bits
// - Short status write clears three status bits
// - Non-volatile write timed, busy, then latch clear
// - Volatile write immediate, busy stays zero
// - All status bits reset to zero
// - Opcode is first byte, MSB first, rising edge
// - Write-type frames need whole byte count
// - While busy only status reads accepted
// - Quad reads refused without quad enable bit
`ifndef SFC_PARAMS_SVH
`define SFC_PARAMS_SVH

`define SFC_OP_READ 8'h03
`define SFC_OP_FAST 8'h0b
`define SFC_OP_DUAL_OUT 8'h3b
`define SFC_OP_QUAD_OUT 8'h6b
`define SFC_OP_DUAL_IO 8'hbb
`define SFC_OP_QUAD_IO 8'heb
`define SFC_OP_WRAP 8'h77
`define SFC_OP_REL_ID 8'hab
`define SFC_OP_SEC_ERASE 8'h44
`define SFC_OP_SEC_PROG 8'h42
`define SFC_OP_SEC_READ 8'h48
`define SFC_OP_LATCH_SET 8'h06
`define SFC_OP_VOL_ARM 8'h50
`define SFC_OP_LATCH_CLR 8'h04
`define SFC_OP_STAT1 8'h05
`define SFC_OP_STAT2 8'h35
`define SFC_OP_STAT_WR 8'h01
`define SFC_OP_PAGE 8'h02
`define SFC_OP_QPAGE 8'h32
`define SFC_OP_ERASE_4K 8'h20
`define SFC_OP_ERASE_32K 8'h52
`define SFC_OP_ERASE_64K 8'hd8
`define SFC_OP_CHIP_A 8'hc7
`define SFC_OP_CHIP_B 8'h60

`define SFC_W1 3'h1
`define SFC_W2 3'h2
`define SFC_W4 3'h4

`define SFC_BUSY_POS 0
`define SFC_LATCH_POS 1
`define SFC_SR1_HI 7
`define SFC_SR1_LO 2
`define SFC_PROT2_POS 8
`define SFC_QUAD_POS 9
`define SFC_LOCK_HI 13
`define SFC_LOCK_LO 10
`define SFC_CMP_POS 14
`define SFC_SR2_LANE 8

`define SFC_SEC_TOP 8'h00
`define SFC_SEC_R1 8'h10
`define SFC_SEC_R2 8'h20
`define SFC_SEC_R3 8'h30

`define SFC_ADDR_BITS 24
`define SFC_BYTE_BITS 8
`define SFC_DUMMY_CLKS 8
`define SFC_QIO_DUMMY_CLKS 4
`define SFC_ID_DUMMY_CLKS 24
`define SFC_WRAP_SLOT 5'h06

`define SFC_FRAME_OPC 6'h08
`define SFC_FRAME_SR_SHORT 6'h10
`define SFC_FRAME_SR_LONG 6'h18
`define SFC_FRAME_ADDR 6'h20
`define SFC_TOTAL_MAX 6'h3f

`define SFC_TW_US 10000
`define SFC_CLK_MHZ 100
`define SFC_DEVICE_CODE 8'h5a

`endif

// *** rtl/sfc_pkg.sv ***
package sfc_pkg;

    typedef enum logic [2:0] {PH_OPC, PH_ADDR, PH_MODE, PH_DUMMY, PH_DOUT, PH_DIN, PH_IDLE} sfc_phase_t;

    typedef struct packed {
        sfc_phase_t phase;
        logic [4:0] bits;
        logic [4:0] len;
        logic [2:0] width;
        logic [7:0] opcode;
        logic [23:0] addr;
        logic [15:0] din;
        logic [2:0] wrap;
        logic [5:0] total;
        logic [2:0] bytephase;
        logic [7:0] shift;
        logic ignore;
        logic seq;
        logic [15:0] st_meta;
        logic [15:0] st_sync;
    } sfc_link_t;

    typedef struct packed {
        logic [3:0] io;
        logic [3:0] oe;
    } sfc_pins_t;

    typedef struct packed {
        logic cs_meta;
        logic cs_sync;
        logic cs_prev;
        logic seq_seen;
        logic write_enable_latch;
        logic vol_arm;
        logic [14:2] prot;
        logic [14:2] pend;
        logic wr_busy;
        logic arr_busy;
        logic [31:0] timer;
        logic arr_req;
        logic [7:0] arr_cmd;
        logic [23:0] arr_addr;
        logic [2:0] wrap;
        logic [15:0] status;
    } sfc_core_t;

endpackage

// *** rtl/sfc_cmd_status.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sfc_params.svh"

module sfc_cmd_status #(
    parameter int unsigned TW_CYCLES = `SFC_TW_US * `SFC_CLK_MHZ,
    parameter logic [7:0] DEVICE_CODE = `SFC_DEVICE_CODE
)(
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic SCLK_I,
    input wire logic CS_N_I,
    input wire logic [3:0] IO_I,
    input wire logic [7:0] MEM_DATA_I,
    input wire logic ARRAY_DONE_I,
    output logic [3:0] IO_O,
    output logic [3:0] IO_OE_O,
    output logic [23:0] MEM_ADDR_O,
    output logic [15:0] STATUS_O,
    output logic ARRAY_REQ_O,
    output logic [7:0] ARRAY_CMD_O,
    output logic [23:0] ARRAY_ADDR_O,
    output logic [2:0] WRAP_O
);

    // DEVICE_CODE default is arbitrary

    function automatic logic [4:0] sfc_span(input int clocks, input logic [2:0] w);
        return 5'(clocks / int'(w) - 1);
    endfunction

    function automatic sfc_pkg::sfc_phase_t sfc_next(input logic [7:0] op, input sfc_pkg::sfc_phase_t ph);
        sfc_pkg::sfc_phase_t nx;
        nx = sfc_pkg::PH_IDLE;
        case (ph)
            sfc_pkg::PH_OPC:
                case (op)
                    `SFC_OP_READ, `SFC_OP_FAST, `SFC_OP_DUAL_OUT, `SFC_OP_QUAD_OUT,
                    `SFC_OP_DUAL_IO, `SFC_OP_QUAD_IO, `SFC_OP_SEC_ERASE, `SFC_OP_SEC_PROG,
                    `SFC_OP_SEC_READ, `SFC_OP_PAGE, `SFC_OP_QPAGE, `SFC_OP_ERASE_4K,
                    `SFC_OP_ERASE_32K, `SFC_OP_ERASE_64K: nx = sfc_pkg::PH_ADDR;
                    `SFC_OP_REL_ID: nx = sfc_pkg::PH_DUMMY;
                    `SFC_OP_STAT1, `SFC_OP_STAT2: nx = sfc_pkg::PH_DOUT;
                    `SFC_OP_STAT_WR, `SFC_OP_WRAP: nx = sfc_pkg::PH_DIN;
                    default: nx = sfc_pkg::PH_IDLE;
                endcase
            sfc_pkg::PH_ADDR:
                case (op)
                    `SFC_OP_READ: nx = sfc_pkg::PH_DOUT;
                    `SFC_OP_FAST, `SFC_OP_DUAL_OUT, `SFC_OP_QUAD_OUT,
                    `SFC_OP_SEC_READ: nx = sfc_pkg::PH_DUMMY;
                    `SFC_OP_DUAL_IO, `SFC_OP_QUAD_IO: nx = sfc_pkg::PH_MODE;
                    `SFC_OP_SEC_PROG, `SFC_OP_PAGE, `SFC_OP_QPAGE: nx = sfc_pkg::PH_DIN;
                    default: nx = sfc_pkg::PH_IDLE;
                endcase
            sfc_pkg::PH_MODE: nx = (op == `SFC_OP_QUAD_IO) ? sfc_pkg::PH_DUMMY : sfc_pkg::PH_DOUT;
            sfc_pkg::PH_DUMMY: nx = sfc_pkg::PH_DOUT;
            sfc_pkg::PH_DOUT: nx = sfc_pkg::PH_DOUT;
            sfc_pkg::PH_DIN: nx = sfc_pkg::PH_DIN;
            default: nx = sfc_pkg::PH_IDLE;
        endcase
        return nx;
    endfunction

    function automatic logic [2:0] sfc_width(input logic [7:0] op, input sfc_pkg::sfc_phase_t ph);
        logic [2:0] w;
        w = `SFC_W1;
        if (ph == sfc_pkg::PH_ADDR || ph == sfc_pkg::PH_MODE) begin
            if (op == `SFC_OP_DUAL_IO)
                w = `SFC_W2;
            else if (op == `SFC_OP_QUAD_IO)
                w = `SFC_W4;
        end
        else if (ph == sfc_pkg::PH_DOUT) begin
            if (op == `SFC_OP_DUAL_OUT || op == `SFC_OP_DUAL_IO)
                w = `SFC_W2;
            else if (op == `SFC_OP_QUAD_OUT || op == `SFC_OP_QUAD_IO)
                w = `SFC_W4;
        end
        return w;
    endfunction

    function automatic logic [4:0] sfc_len(input logic [7:0] op, input sfc_pkg::sfc_phase_t ph, input logic [2:0] w);
        logic [4:0] n;
        case (ph)
            sfc_pkg::PH_ADDR: n = sfc_span(`SFC_ADDR_BITS, w);
            sfc_pkg::PH_DUMMY:
                if (op == `SFC_OP_REL_ID)
                    n = sfc_span(`SFC_ID_DUMMY_CLKS, `SFC_W1);
                else if (op == `SFC_OP_QUAD_IO)
                    n = sfc_span(`SFC_QIO_DUMMY_CLKS, `SFC_W1);
                else
                    n = sfc_span(`SFC_DUMMY_CLKS, `SFC_W1);
            default: n = sfc_span(`SFC_BYTE_BITS, w);
        endcase
        return n;
    endfunction

    function automatic logic sfc_sec_ok(input logic [23:0] a);
        return (a[23:16] == `SFC_SEC_TOP) && (a[15:8] == `SFC_SEC_R1 || a[15:8] == `SFC_SEC_R2 ||
            a[15:8] == `SFC_SEC_R3);
    endfunction

    function automatic logic [14:2] sfc_merge(input logic [14:2] old, input logic [15:0] din,
        input logic long_w, input logic vol);
        logic [14:2] nv;
        nv = old;
        if (long_w) begin
            nv[`SFC_SR1_HI:`SFC_SR1_LO] = din[`SFC_SR1_HI+`SFC_SR2_LANE:`SFC_SR1_LO+`SFC_SR2_LANE];
            nv[`SFC_CMP_POS:`SFC_PROT2_POS] = din[`SFC_CMP_POS-`SFC_SR2_LANE:0];
        end
        else begin
            nv[`SFC_SR1_HI:`SFC_SR1_LO] = din[`SFC_SR1_HI:`SFC_SR1_LO];
            nv[`SFC_CMP_POS] = 1'b0;
            nv[`SFC_QUAD_POS] = 1'b0;
            nv[`SFC_PROT2_POS] = 1'b0;
        end
        nv[`SFC_LOCK_HI:`SFC_LOCK_LO] = nv[`SFC_LOCK_HI:`SFC_LOCK_LO] | old[`SFC_LOCK_HI:`SFC_LOCK_LO];
        if (vol)
            nv[`SFC_PROT2_POS] = nv[`SFC_PROT2_POS] | old[`SFC_PROT2_POS];
        return nv;
    endfunction

    sfc_pkg::sfc_link_t l_r;
    sfc_pkg::sfc_link_t l_nxt;
    sfc_pkg::sfc_pins_t p_r;
    sfc_pkg::sfc_pins_t p_nxt;
    sfc_pkg::sfc_core_t c_r;
    sfc_pkg::sfc_core_t c_nxt;
    logic in_frame_r;
    logic frame_rst_n;
    logic [7:0] src_byte;
    logic [7:0] cur_byte;

    // Chip select high clears the frame flag and releases the lines at once
    assign frame_rst_n = RSTN_I & ~CS_N_I;

    // The link clock stops between frames, so the first edge of a frame is found by this flag
    always_ff @(posedge SCLK_I or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
            in_frame_r <= 1'b0;
        else
            in_frame_r <= 1'b1;
    end

    always_comb
    begin
        case (l_r.opcode)
            `SFC_OP_STAT1: src_byte = l_r.st_sync[7:0];
            `SFC_OP_STAT2: src_byte = l_r.st_sync[15:8];
            `SFC_OP_REL_ID: src_byte = DEVICE_CODE;
            default: src_byte = MEM_DATA_I;
        endcase
        cur_byte = (l_r.bits == 5'h00) ? src_byte : l_r.shift;
    end

    always_comb
    begin
        sfc_pkg::sfc_link_t b;
        sfc_pkg::sfc_phase_t nx;
        b = l_r;
        nx = sfc_pkg::PH_IDLE;
        if (!in_frame_r) begin
            b.phase = sfc_pkg::PH_OPC;
            b.bits = 5'h00;
            b.len = sfc_span(`SFC_BYTE_BITS, `SFC_W1);
            b.width = `SFC_W1;
            b.opcode = 8'h00;
            b.din = 16'h0000;
            b.total = 6'h00;
            b.bytephase = 3'h0;
            b.ignore = 1'b0;
            b.seq = ~l_r.seq;
        end
        l_nxt = b;
        l_nxt.st_meta = c_r.status;
        l_nxt.st_sync = b.st_meta;
        l_nxt.total = (b.total == `SFC_TOTAL_MAX) ? b.total : b.total + 6'h01;
        l_nxt.bytephase = b.bytephase + 3'h1;
        case (b.phase)
            sfc_pkg::PH_OPC: l_nxt.opcode = {b.opcode[6:0], IO_I[0]};
            sfc_pkg::PH_ADDR, sfc_pkg::PH_MODE:
                if (b.phase == sfc_pkg::PH_ADDR) begin
                    case (b.width)
                        `SFC_W2: l_nxt.addr = {b.addr[21:0], IO_I[1:0]};
                        `SFC_W4: l_nxt.addr = {b.addr[19:0], IO_I[3:0]};
                        default: l_nxt.addr = {b.addr[22:0], IO_I[0]};
                    endcase
                end
            sfc_pkg::PH_DIN: begin
                l_nxt.din = {b.din[14:0], IO_I[0]};
                if (b.opcode == `SFC_OP_WRAP && b.bits == `SFC_WRAP_SLOT)
                    l_nxt.wrap = IO_I[2:0];
            end
            sfc_pkg::PH_DOUT:
                case (b.width)
                    `SFC_W2: l_nxt.shift = {cur_byte[5:0], 2'b00};
                    `SFC_W4: l_nxt.shift = {cur_byte[3:0], 4'h0};
                    default: l_nxt.shift = {cur_byte[6:0], 1'b0};
                endcase
            default: l_nxt.shift = b.shift;
        endcase
        if (b.phase != sfc_pkg::PH_IDLE && b.bits == b.len) begin
            if (b.phase == sfc_pkg::PH_OPC) begin
                nx = sfc_next(l_nxt.opcode, sfc_pkg::PH_OPC);
                if (b.st_sync[`SFC_BUSY_POS] && l_nxt.opcode != `SFC_OP_STAT1 &&
                    l_nxt.opcode != `SFC_OP_STAT2) begin
                    nx = sfc_pkg::PH_IDLE;
                    l_nxt.ignore = 1'b1;
                end
                if (!b.st_sync[`SFC_QUAD_POS] && (l_nxt.opcode == `SFC_OP_QUAD_OUT ||
                    l_nxt.opcode == `SFC_OP_QUAD_IO)) begin
                    nx = sfc_pkg::PH_IDLE;
                    l_nxt.ignore = 1'b1;
                end
            end
            else begin
                nx = sfc_next(b.opcode, b.phase);
                // Status and ID streams repeat the same byte; only memory bytes step the address
                if (b.phase == sfc_pkg::PH_DOUT && b.opcode != `SFC_OP_STAT1 &&
                    b.opcode != `SFC_OP_STAT2 && b.opcode != `SFC_OP_REL_ID)
                    l_nxt.addr = b.addr + 24'h000001;
            end
            l_nxt.phase = nx;
            l_nxt.bits = 5'h00;
            l_nxt.width = sfc_width(l_nxt.opcode, nx);
            l_nxt.len = sfc_len(l_nxt.opcode, nx, sfc_width(l_nxt.opcode, nx));
        end
        else begin
            l_nxt.bits = b.bits + 5'h01;
        end
    end

    always_ff @(posedge SCLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
            l_r <= '0;
        else
            l_r <= l_nxt;
    end

    always_comb
    begin
        p_nxt = '0;
        if (l_r.phase == sfc_pkg::PH_DOUT) begin
            case (l_r.width)
                `SFC_W2: begin
                    p_nxt.io = {2'b00, cur_byte[7:6]};
                    p_nxt.oe = 4'h3;
                end
                `SFC_W4: begin
                    p_nxt.io = cur_byte[7:4];
                    p_nxt.oe = 4'hf;
                end
                default: begin
                    p_nxt.io = {2'b00, cur_byte[7], 1'b0};
                    p_nxt.oe = 4'h2;
                end
            endcase
        end
    end

    // Data leaves on falling edges so it is settled for the host's rising-edge sample
    always_ff @(negedge SCLK_I or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
            p_r <= '0;
        else
            p_r <= p_nxt;
    end

    always_comb
    begin
        logic frame_end;
        logic busy;
        logic long_w;
        logic [14:2] merged;
        frame_end = 1'b0;
        busy = 1'b0;
        long_w = 1'b0;
        merged = c_r.prot;
        c_nxt = c_r;
        c_nxt.cs_meta = CS_N_I;
        c_nxt.cs_sync = c_r.cs_meta;
        c_nxt.cs_prev = c_r.cs_sync;
        c_nxt.arr_req = 1'b0;
        // Link fields are read only after chip select has risen and the link clock is still
        frame_end = c_r.cs_sync & ~c_r.cs_prev & (l_r.seq != c_r.seq_seen);
        if (c_r.cs_sync & ~c_r.cs_prev)
            c_nxt.seq_seen = l_r.seq;
        busy = c_r.wr_busy | c_r.arr_busy;
        if (c_r.wr_busy) begin
            if (c_r.timer == TW_CYCLES - 1) begin
                c_nxt.wr_busy = 1'b0;
                c_nxt.prot = c_r.pend;
                c_nxt.write_enable_latch = 1'b0;
            end
            else begin
                c_nxt.timer = c_r.timer + 32'h00000001;
            end
        end
        if (c_r.arr_busy && ARRAY_DONE_I) begin
            c_nxt.arr_busy = 1'b0;
            c_nxt.write_enable_latch = 1'b0;
        end
        if (frame_end && !l_r.ignore && !busy) begin
            case (l_r.opcode)
                `SFC_OP_LATCH_SET: begin
                    c_nxt.vol_arm = 1'b0;
                    if (l_r.total == `SFC_FRAME_OPC)
                        c_nxt.write_enable_latch = 1'b1;
                end
                `SFC_OP_LATCH_CLR:
                    if (l_r.total == `SFC_FRAME_OPC) begin
                        c_nxt.write_enable_latch = 1'b0;
                        c_nxt.vol_arm = 1'b0;
                    end
                `SFC_OP_VOL_ARM:
                    if (l_r.total == `SFC_FRAME_OPC)
                        c_nxt.vol_arm = 1'b1;
                `SFC_OP_STAT1, `SFC_OP_STAT2: c_nxt.vol_arm = c_r.vol_arm;
                `SFC_OP_STAT_WR: begin
                    c_nxt.vol_arm = 1'b0;
                    long_w = (l_r.total == `SFC_FRAME_SR_LONG);
                    merged = sfc_merge(c_r.prot, l_r.din, long_w, c_r.vol_arm);
                    if (long_w || l_r.total == `SFC_FRAME_SR_SHORT) begin
                        if (c_r.vol_arm)
                            c_nxt.prot = merged;
                        else if (c_r.write_enable_latch) begin
                            c_nxt.pend = merged;
                            c_nxt.wr_busy = 1'b1;
                            c_nxt.timer = 32'h00000000;
                        end
                    end
                end
                `SFC_OP_WRAP: begin
                    c_nxt.vol_arm = 1'b0;
                    if (l_r.total == `SFC_FRAME_SR_SHORT)
                        c_nxt.wrap = l_r.wrap;
                end
                `SFC_OP_PAGE, `SFC_OP_QPAGE, `SFC_OP_SEC_PROG, `SFC_OP_SEC_ERASE,
                `SFC_OP_ERASE_4K, `SFC_OP_ERASE_32K, `SFC_OP_ERASE_64K,
                `SFC_OP_CHIP_A, `SFC_OP_CHIP_B: begin
                    c_nxt.vol_arm = 1'b0;
                    if (c_r.write_enable_latch && l_r.bytephase == 3'h0 &&
                        (((l_r.opcode == `SFC_OP_CHIP_A || l_r.opcode == `SFC_OP_CHIP_B) &&
                          l_r.total == `SFC_FRAME_OPC) ||
                         ((l_r.opcode == `SFC_OP_ERASE_4K || l_r.opcode == `SFC_OP_ERASE_32K ||
                           l_r.opcode == `SFC_OP_ERASE_64K) && l_r.total == `SFC_FRAME_ADDR) ||
                         (l_r.opcode == `SFC_OP_SEC_ERASE && l_r.total == `SFC_FRAME_ADDR &&
                          sfc_sec_ok(l_r.addr)) ||
                         (l_r.opcode == `SFC_OP_SEC_PROG && l_r.total > `SFC_FRAME_ADDR &&
                          sfc_sec_ok(l_r.addr)) ||
                         ((l_r.opcode == `SFC_OP_PAGE || l_r.opcode == `SFC_OP_QPAGE) &&
                          l_r.total > `SFC_FRAME_ADDR))) begin
                        c_nxt.arr_req = 1'b1;
                        c_nxt.arr_cmd = l_r.opcode;
                        c_nxt.arr_addr = l_r.addr;
                        c_nxt.arr_busy = 1'b1;
                    end
                end
                default: c_nxt.vol_arm = 1'b0;
            endcase
        end
        c_nxt.status = {1'b0, c_nxt.prot, c_nxt.write_enable_latch, c_nxt.wr_busy | c_nxt.arr_busy};
    end

    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
            c_r <= '0;
        else
            c_r <= c_nxt;
    end

    assign IO_O = p_r.io;
    assign IO_OE_O = p_r.oe;
    assign MEM_ADDR_O = l_r.addr;
    assign STATUS_O = c_r.status;
    assign ARRAY_REQ_O = c_r.arr_req;
    assign ARRAY_CMD_O = c_r.arr_cmd;
    assign ARRAY_ADDR_O = c_r.arr_addr;
    assign WRAP_O = c_r.wrap;

endmodule
`default_nettype wire

// *** sim/sfc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfc_host_model (
    output logic SCLK_O,
    output logic CS_N_O,
    output logic [3:0] IO_O,
    input wire logic [3:0] IO_I,
    input wire logic [3:0] OE_I
);
    // Link clock rests low between frames
    initial
    begin
        SCLK_O = 1'b0;
        CS_N_O = 1'b1;
        IO_O = 4'h5;
    end
    task automatic frame(input logic [63:0] d, input int n, input int k, input int w,
                         output logic [31:0] rd, output logic oe);
        rd = '0;
        oe = 1'b0;
        #7 CS_N_O = 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            IO_O = {4{d[i]}};
            #16 SCLK_O = 1'b1;
            #16 SCLK_O = 1'b0;
        end
        for (int i = 0; i < k; i++)
        begin
            #16 SCLK_O = 1'b1;
            oe = oe | (|OE_I);
            rd = (w == 4) ? {rd[27:0], IO_I} : (w == 2) ? {rd[29:0], IO_I[1:0]} : {rd[30:0], IO_I[1]};
            // Released lines toggle so a stale value cannot pass as data
            IO_O = ~IO_O;
            #16 SCLK_O = 1'b0;
        end
        #8 CS_N_O = 1'b1;
        #100;
    endtask
endmodule
`default_nettype wire

// *** sim/sfc_cmd_status_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfc_cmd_status_properties (
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic SCLK_I,
    input wire logic CS_N_I,
    input wire logic ARRAY_DONE_I,
    input wire logic [3:0] IO_OE_O,
    input wire logic [15:0] STATUS_O,
    input wire logic ARRAY_REQ_O,
    input wire logic [7:0] ARRAY_CMD_O,
    input wire logic [2:0] WRAP_O
);
    logic [3:0] edge_cnt_r;
    always_ff @(posedge SCLK_I or posedge CS_N_I)
    begin
        if (CS_N_I)
            edge_cnt_r <= 4'h0;
        else if (edge_cnt_r != 4'hf)
            edge_cnt_r <= edge_cnt_r + 4'h1;
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    a_oe_released: assert property (CS_N_I |-> IO_OE_O == 4'h0)
        else $error("lines driven while deselected");
    a_oe_legal: assert property (IO_OE_O inside {4'h0, 4'h2, 4'h3, 4'hf})
        else $error("illegal enable pattern");
    a_req_single: assert property (ARRAY_REQ_O |=> !ARRAY_REQ_O)
        else $error("request longer than one cycle");
    a_req_gated: assert property (ARRAY_REQ_O |-> $past(STATUS_O[1]) && !$past(STATUS_O[0]))
        else $error("request without latch or while busy");
    a_done_clears: assert property (ARRAY_DONE_I && STATUS_O[0] |-> ##[1:4] STATUS_O[1:0] == 2'b00)
        else $error("busy or latch kept after completion");
    a_spare_zero: assert property (STATUS_O[15] == 1'b0)
        else $error("read-only bit set");
    a_lock_kept: assert property (($past(STATUS_O[13:10]) & ~STATUS_O[13:10]) == 4'h0)
        else $error("lock bit cleared");
    a_latch_frame: assert property ($rose(STATUS_O[1]) |-> CS_N_I)
        else $error("latch set inside a frame");
    a_cmd_with_req: assert property ($changed(ARRAY_CMD_O) |-> ARRAY_REQ_O)
        else $error("command changed without request");
    a_wrap_commit: assert property ($changed(WRAP_O) |-> CS_N_I)
        else $error("wrap changed inside a frame");
    a_opcode_quiet: assert property (@(posedge SCLK_I) disable iff (!RSTN_I || CS_N_I)
        edge_cnt_r < 4'h8 |-> IO_OE_O == 4'h0)
        else $error("lines driven during opcode");
endmodule
`default_nettype wire

// *** sim/sfc_cmd_status_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfc_cmd_status_bench;
    localparam int TW = 200;
    localparam logic [7:0] DEV = 8'h5a; // Arbitrary value
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic done = 1'b0;
    logic sclk, cs_n, req, oe;
    logic [3:0] io_in, io_out, io_oe;
    logic [7:0] mem_data, cmd;
    logic [23:0] mem_addr, addr;
    logic [15:0] status;
    logic [2:0] wrap;
    logic [31:0] rd;
    int n_mismatch = 0;
    int check_count = 0;
    int nreq = 0;
    int run = 0;
    int last_len = 0;
    always #5 clk = ~clk;
    // Fixed pattern keeps expected bytes derivable from the address
    assign mem_data = mem_addr[7:0] ^ 8'h3c;
    always @(posedge clk)
    begin
        if (req === 1'b1)
            nreq++;
        if (status[0] === 1'b1)
            run++;
        else if (run != 0)
        begin
            last_len = run;
            run = 0;
        end
    end
    sfc_cmd_status #(.TW_CYCLES(TW), .DEVICE_CODE(DEV)) u_sfc_cmd_status (
        .CLK_I(clk), .RSTN_I(rstn), .SCLK_I(sclk), .CS_N_I(cs_n), .IO_I(io_in),
        .MEM_DATA_I(mem_data), .ARRAY_DONE_I(done), .IO_O(io_out), .IO_OE_O(io_oe),
        .MEM_ADDR_O(mem_addr), .STATUS_O(status), .ARRAY_REQ_O(req), .ARRAY_CMD_O(cmd),
        .ARRAY_ADDR_O(addr), .WRAP_O(wrap));
    sfc_host_model u_sfc_host_model (.SCLK_O(sclk), .CS_N_O(cs_n), .IO_O(io_in), .IO_I(io_out), .OE_I(io_oe));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic op(input logic [63:0] d, input int n, input int k, input int w);
        @(posedge clk);
        u_sfc_host_model.frame(d, n, k, w, rd, oe);
    endtask
    task automatic rdchk(input logic [63:0] d, input int n, input int k, input int w, input logic [31:0] exp);
        op(d, n, k, w);
        chk(rd, exp);
    endtask
    task automatic st(input logic [15:0] exp);
        chk({16'h0, status}, {16'h0, exp});
    endtask
    task automatic idle();
        repeat (400)
            if (status[0] !== 1'b0)
                @(posedge clk);
        // Let the run counter see the falling busy edge before last_len is read
        repeat (2) @(posedge clk);
    endtask
    task automatic finish_op();
        @(posedge clk);
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    task automatic close_out();
        $display("Checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        #500000;
        n_mismatch++;
        close_out();
    end
    initial
    begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        rdchk(64'h05, 8, 16, 1, 32'h0);
        rdchk(64'h35, 8, 16, 1, 32'h0);
        op(64'h06, 8, 0, 1);
        st(16'h0002);
        rdchk(64'h05, 8, 16, 1, 32'h0202);
        op(64'h04, 8, 0, 1);
        st(16'h0000);
        op(64'h06, 8, 0, 1);
        op(64'h01ff82, 24, 0, 1);
        rdchk(64'h05, 8, 16, 1, 32'h0303);
        op(64'h7702, 16, 0, 1);
        idle();
        chk(32'(last_len), TW);
        st(16'h02fc);
        chk({29'h0, wrap}, 32'h0);
        op(64'h7702, 16, 0, 1);
        chk({29'h0, wrap}, 32'h7);
        rdchk(64'h03000010, 32, 16, 1, 32'h2c2d);
        rdchk(64'h0b00001000, 40, 16, 1, 32'h2c2d);
        rdchk(64'h3b00001000, 40, 8, 2, 32'h2c2d);
        rdchk(64'h6b00001000, 40, 4, 4, 32'h2c2d);
        rdchk(64'hbb0000, 24, 8, 2, 32'h3c3d);
        rdchk(64'heb000, 20, 4, 4, 32'h3c3d);
        rdchk(64'hab000000, 32, 16, 1, {16'h0, DEV, DEV});
        op(64'h50, 8, 0, 1);
        st(16'h02fc);
        op(64'h0100, 16, 0, 1);
        st(16'h0000);
        op(64'h6b00001000, 40, 4, 4);
        chk({31'h0, oe}, 32'h0);
        op(64'h06, 8, 0, 1);
        op(64'h01fc0, 20, 0, 1);
        st(16'h0002);
        op(64'h010004, 24, 0, 1);
        idle();
        st(16'h0400);
        op(64'h50, 8, 0, 1);
        op(64'h010000, 24, 0, 1);
        st(16'h0400);
        op(64'h20001000, 32, 0, 1);
        chk(32'(nreq), 32'h0);
        op(64'h06, 8, 0, 1);
        op(64'h20001000, 32, 0, 1);
        chk({cmd, addr}, 32'h20001000);
        op(64'h04, 8, 0, 1);
        st(16'h0403);
        finish_op();
        st(16'h0400);
        op(64'h06, 8, 0, 1);
        op(64'h44004000, 32, 0, 1);
        chk(32'(nreq), 32'h1);
        op(64'h44002000, 32, 0, 1);
        chk({cmd, addr}, 32'h44002000);
        finish_op();
        st(16'h0400);
        close_out();
    end
endmodule
bind sfc_cmd_status sfc_cmd_status_properties u_sfc_cmd_status_properties (
    .CLK_I(CLK_I), .RSTN_I(RSTN_I), .SCLK_I(SCLK_I), .CS_N_I(CS_N_I), .ARRAY_DONE_I(ARRAY_DONE_I),
    .IO_OE_O(IO_OE_O), .STATUS_O(STATUS_O), .ARRAY_REQ_O(ARRAY_REQ_O), .ARRAY_CMD_O(ARRAY_CMD_O),
    .WRAP_O(WRAP_O));
`default_nettype wire
